/* File: dv/bmd_top_sva.sv */
// assertion checker for the memory decoder top ports
module bmd_top_chk #(
  parameter bit BIG_PROG = 1'b1
) (
  // clocking
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core and program memory
  input wire logic        core_step,
  input wire logic        core_irq_take,
  input wire logic [12:0] pm_fetch_addr,
  input wire logic [12:0] pm_rd_addr,
  input wire logic [13:0] pm_rd_data
);
  localparam logic [12:0] MASK = BIG_PROG ? 13'h1fff : 13'h0fff;
  logic quiet;
  assign quiet = !(psel && pwrite) && !core_irq_take;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_vec_a:
    assert property ($fell(sys_rst) |-> pm_fetch_addr == 13'h0000)
    else $error("pc not at reset vector");
  irq_vec_a:
    assert property (ce && core_irq_take |=> pm_fetch_addr == 13'h0004)
    else $error("pc not at interrupt vector");
  pc_step_a:
    assert property (ce && core_step && quiet |=>
      pm_fetch_addr == (($past(pm_fetch_addr) + 13'h0001) & MASK))
    else $error("pc step wrong");
  pc_hold_a:
    assert property (ce && !core_step && quiet |=> $stable(pm_fetch_addr))
    else $error("pc moved without cause");
  ready_wait_a:
    assert property (ce && psel && !penable |=> !pready ##1 pready)
    else $error("apb answer late or early");
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmap_a:
    assert property (pready && paddr[9:2] > 8'h85 |-> pslverr)
    else $error("unmapped index not refused");
  err_mapped_a:
    assert property (pready && paddr[9:2] <= 8'h85 && paddr[11:10] == 2'b00
      && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped index refused");
  rd_zero_a:
    assert property (pready && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
endmodule : bmd_top_chk

bind bmd_top bmd_top_chk #(.BIG_PROG(BIG_PROG)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core_step(core_step),
  .core_irq_take(core_irq_take), .pm_fetch_addr(pm_fetch_addr),
  .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data)
);

/* File: dv/tb.sv */
// self-checking bench for the memory decoder top
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin \
      n_fail++; \
      $display("Error %0t: got %h expected %h", $time, a, b); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        sys_rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        core_step;
  logic        core_irq_take;
  logic [12:0] pm_fetch_addr;
  logic [12:0] pm_rd_addr;
  logic [13:0] pm_rd_data;
  logic [31:0] prdata_s;
  logic        pready_s;
  logic        pslverr_s;
  logic [12:0] pm_fetch_addr_s;
  logic [12:0] pm_rd_addr_s;
  logic [7:0]  rv;
  logic [7:0]  rv_s;
  logic        ev;
  int          n_fail;
  int          num_checks;

  bmd_top #(.BIG_PROG(1'b1), .BIG_PKG(1'b1)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_step(core_step),
    .core_irq_take(core_irq_take), .pm_fetch_addr(pm_fetch_addr),
    .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data)
  );

  // small variant: 4K program space, no fourth and fifth ports
  bmd_top #(.BIG_PROG(1'b0), .BIG_PKG(1'b0)) u_dut_s (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s),
    .pready(pready_s), .pslverr(pslverr_s), .core_step(core_step),
    .core_irq_take(core_irq_take), .pm_fetch_addr(pm_fetch_addr_s),
    .pm_rd_addr(pm_rd_addr_s), .pm_rd_data(pm_rd_data)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // program word derived from its address
  always @(posedge clk) begin
    pm_rd_data <= {1'b1, pm_rd_addr};
  end

  task automatic close_out;
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      close_out();
    end
    rv = prdata[7:0];
    rv_s = prdata_s[7:0];
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK(rv, e)
  endtask : rd

  initial begin
    n_fail = 0;
    num_checks = 0;
    sys_rst <= 1'b1;
    ce <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    core_step <= 1'b0;
    core_irq_take <= 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK(pm_fetch_addr, 13'h0000)
    rd(8'h84, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr(8'h03, {1'b0, 2'(b), 5'h00});
      wr(8'h20, 8'h10 + 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      wr(8'h03, {1'b0, 2'(b), 5'h00});
      rd(8'h20, 8'h10 + 8'(b));
      `CHK(rv_s, 8'h12 + 8'(b % 2))
      rd(8'h03, {1'b0, 2'(b), 5'h00});
    end
    wr(8'h75, 8'h5a);
    wr(8'h03, 8'h00);
    rd(8'h75, 8'h5a);
    rd(8'h15, 8'h00);
    wr(8'h08, 8'ha5);
    rd(8'h08, 8'ha5);
    `CHK(rv_s, 8'h00)
    wr(8'h03, 8'h40);
    rd(8'h08, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'ha0);
    rd(8'h00, 8'h11);
    wr(8'h00, 8'h77);
    wr(8'h03, 8'h20);
    rd(8'h20, 8'h77);
    wr(8'h04, 8'h80);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h80);
    xfer(1'b0, 8'h86, 8'h00);
    `CHK(ev, 1'b1)
    `CHK(rv, 8'h00)
    `CHK(pslverr_s, 1'b1)
    wr(8'h80, 8'h34);
    wr(8'h81, 8'h12);
    @(negedge clk);
    `CHK(pm_rd_addr, 13'h1234)
    `CHK(pm_rd_addr_s, 13'h0234)
    repeat (4) @(posedge clk);
    rd(8'h82, 8'h34);
    rd(8'h83, 8'h32);
    core_step <= 1'b1;
    rd(8'h03, 8'h20);
    core_step <= 1'b0;
    wr(8'h0a, 8'h1f);
    wr(8'h02, 8'hff);
    @(negedge clk);
    `CHK(pm_fetch_addr, 13'h1fff)
    `CHK(pm_fetch_addr_s, 13'h0fff)
    @(posedge clk);
    core_step <= 1'b1;
    @(posedge clk);
    core_step <= 1'b0;
    @(negedge clk);
    `CHK(pm_fetch_addr, 13'h0000)
    @(posedge clk);
    core_irq_take <= 1'b1;
    @(posedge clk);
    core_irq_take <= 1'b0;
    @(negedge clk);
    `CHK(pm_fetch_addr, 13'h0004)
    rd(8'h84, 8'h04);
    @(posedge clk);
    ce        <= 1'b0;
    core_step <= 1'b1;
    repeat (3) @(posedge clk);
    ce        <= 1'b1;
    core_step <= 1'b0;
    @(negedge clk);
    `CHK(pm_fetch_addr, 13'h0004)
    close_out();
  end
endmodule : tb

/* File: src/bmd_cfg.svh */
// offsets, field positions, reset values and vectors of the memory decoder
`ifndef BMD_CFG_SVH
`define BMD_CFG_SVH

// register indexes within a bank (byte address on apb is four times these)
`define BMD_IDX_INDIRECT   7'h00
`define BMD_IDX_PCNT_LOW   7'h02
`define BMD_IDX_STATUS     7'h03
`define BMD_IDX_FSP        7'h04
`define BMD_IDX_PORT4_DAT  7'h08
`define BMD_IDX_PORT5_DAT  7'h09
`define BMD_IDX_PCNT_LATCH 7'h0a

// bank-0 offset where general purpose ram starts, shared and upper regions
`define BMD_GPR_LOW        7'h20
`define BMD_GPR_SHARED     7'h70
`define BMD_GPR_UPPER      7'h10

// control window above the banked data window
`define BMD_IDX_PMR_ADDR_LO 8'h80
`define BMD_IDX_PMR_ADDR_HI 8'h81
`define BMD_IDX_PMR_DATA_LO 8'h82
`define BMD_IDX_PMR_DATA_HI 8'h83
`define BMD_IDX_PC_LO       8'h84
`define BMD_IDX_PC_HI       8'h85

// status word fields
`define BMD_STAT_BANK_HI   6
`define BMD_STAT_BANK_LO   5
`define BMD_STAT_IND_HI    7

// reset values
`define BMD_RST_STATUS     8'h00
`define BMD_RST_BYTE       8'h00

// program space
`define BMD_PC_W           13
`define BMD_PM_W           14
`define BMD_RESET_VEC      13'h0000
`define BMD_IRQ_VEC        13'h0004
`define BMD_MASK_8K        13'h1fff
`define BMD_MASK_4K        13'h0fff

`endif

/* File: src/bmd_if.sv */
// carriers between the decoder top and its ram and program counter
interface bmd_mem_if;
  logic       we;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ram (input we, input addr, input wdata, output rdata);
  modport req (output we, output addr, output wdata, input rdata);
endinterface : bmd_mem_if

interface bmd_pc_if;
  logic        step;
  logic        irq;
  logic        load;
  logic [12:0] load_val;
  logic [12:0] pc;
  modport ctr (input step, input irq, input load, input load_val,
               output pc);
  modport req (output step, output irq, output load, output load_val,
               input pc);
endinterface : bmd_pc_if

/* File: src/bmd_pc.sv */
// 13-bit program counter with vectors and wraparound
`include "bmd_cfg.svh"

module bmd_pc #(
  parameter bit BIG_PROG = 1'b1
) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // control
  bmd_pc_if.ctr    pcb
);

  localparam logic [12:0] MASK = BIG_PROG ? `BMD_MASK_8K : `BMD_MASK_4K;

  logic [12:0] pc_reg;
  logic [12:0] pc_next;

  always_comb begin
    pc_next = pc_reg;
    if (pcb.irq) begin
      pc_next = `BMD_IRQ_VEC;
    end else if (pcb.load) begin
      pc_next = pcb.load_val & MASK;
    end else if (pcb.step) begin
      pc_next = (pc_reg + 13'h0001) & MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_reg <= `BMD_RESET_VEC;
    end else if (ce) begin
      pc_reg <= pc_next;
    end
  end

  assign pcb.pc = pc_reg;

endmodule : bmd_pc

/* File: src/bmd_pkg.sv */
// types shared by the memory decoder modules
package bmd_pkg;

  typedef enum logic [1:0] {
    BMD_IDLE = 2'b00,
    BMD_DATA = 2'b01,
    BMD_DONE = 2'b10
  } bmd_apb_e;

  typedef enum logic [2:0] {
    BMD_K_NONE   = 3'b000,
    BMD_K_PCNT_LOW   = 3'b001,
    BMD_K_STATUS     = 3'b010,
    BMD_K_FSP        = 3'b011,
    BMD_K_PCNT_LATCH = 3'b100,
    BMD_K_PORT       = 3'b101,
    BMD_K_GPR        = 3'b110
  } bmd_kind_e;

  typedef logic [8:0] bmd_faddr_t;

endpackage : bmd_pkg

/* File: src/bmd_ram.sv */
// general purpose data ram, single port, registered read
module bmd_ram (
  // clocking
  input wire logic clk,
  input wire logic ce,
  // access
  bmd_mem_if.ram   mem
);

  logic [7:0] store [0:511];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (ce && mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata_reg <= store[mem.addr];
    end
  end

  assign mem.rdata = rdata_reg;

endmodule : bmd_ram

/* File: src/bmd_top.sv */
// banked data memory decoder with program counter and apb access
`include "bmd_cfg.svh"

module bmd_top #(
  parameter bit BIG_PROG = 1'b1,
  parameter bit BIG_PKG  = 1'b1
) (
  // clocking
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core sequencing
  input  wire logic        core_step,
  input  wire logic        core_irq_take,
  // program memory fetch bus
  output logic      [12:0] pm_fetch_addr,
  // program memory data read bus
  output logic      [12:0] pm_rd_addr,
  input  wire logic [13:0] pm_rd_data
);

  localparam logic [12:0] PMASK = BIG_PROG ? `BMD_MASK_8K : `BMD_MASK_4K;

  bmd_mem_if mem ();
  bmd_pc_if  pcb ();

  bmd_ram u_ram (
    .clk (clk),
    .ce  (ce),
    .mem (mem)
  );

  bmd_pc #(
    .BIG_PROG (BIG_PROG)
  ) u_pc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .pcb     (pcb)
  );

  bmd_pkg::bmd_apb_e  state_reg;
  logic [7:0]         status_reg;
  logic [7:0]         fsp_reg;
  logic [7:0]         pc_latch_reg;
  logic [7:0]         port_reg [0:3];
  logic [12:0]        pmr_addr_reg;
  logic [13:0]        pmr_data_reg;
  logic [31:0]        prdata_reg;
  logic               pslverr_reg;

  logic [7:0]         idx;
  logic               mapped;
  logic               in_data;
  bmd_pkg::bmd_faddr_t faddr;
  logic [1:0]         bank;
  logic [6:0]         off;
  bmd_pkg::bmd_kind_e kind;
  logic [8:0]         phys;
  logic [1:0]         port_sel;
  logic               wr_fire;
  logic [31:0]        rd_val;

  // apb decode
  assign idx     = paddr[9:2];
  assign mapped  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                   (idx <= `BMD_IDX_PC_HI);
  assign in_data = mapped && !idx[7];

  always_comb begin
    if (idx[6:0] == `BMD_IDX_INDIRECT) begin
      faddr = {status_reg[`BMD_STAT_IND_HI], fsp_reg};
    end else begin
      faddr = {status_reg[`BMD_STAT_BANK_HI],
               status_reg[`BMD_STAT_BANK_LO], idx[6:0]};
    end
  end

  assign bank     = faddr[8:7];
  assign off      = faddr[6:0];
  assign port_sel = {bank[0], off[0]};

  // file address to register kind and ram location
  always_comb begin
    kind = bmd_pkg::BMD_K_NONE;
    phys = 9'h000;
    unique case (off)
      `BMD_IDX_INDIRECT: kind = bmd_pkg::BMD_K_NONE;
      `BMD_IDX_PCNT_LOW: kind = bmd_pkg::BMD_K_PCNT_LOW;
      `BMD_IDX_STATUS:   kind = bmd_pkg::BMD_K_STATUS;
      `BMD_IDX_FSP:      kind = bmd_pkg::BMD_K_FSP;
      `BMD_IDX_PCNT_LATCH: kind = bmd_pkg::BMD_K_PCNT_LATCH;
      `BMD_IDX_PORT4_DAT, `BMD_IDX_PORT5_DAT: begin
        if (BIG_PKG && !bank[1]) begin
          kind = bmd_pkg::BMD_K_PORT;
        end
      end
      default: begin
        if (BIG_PROG) begin
          if (bank != 2'b00 && off >= `BMD_GPR_SHARED) begin
            kind = bmd_pkg::BMD_K_GPR;
            phys = {2'b00, off};
          end else if (bank == 2'b00 && off >= `BMD_GPR_LOW) begin
            kind = bmd_pkg::BMD_K_GPR;
            phys = {2'b00, off};
          end else if (bank == 2'b01 && off >= `BMD_GPR_LOW) begin
            kind = bmd_pkg::BMD_K_GPR;
            phys = {bank, off};
          end else if (bank[1] && off >= `BMD_GPR_UPPER) begin
            kind = bmd_pkg::BMD_K_GPR;
            phys = {bank, off};
          end
        end else if (off >= `BMD_GPR_LOW) begin
          kind = bmd_pkg::BMD_K_GPR;
          phys = {1'b0, bank[0], off};
        end
      end
    endcase
  end

  // apb handshake: setup, one capture cycle, then ready
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= bmd_pkg::BMD_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        bmd_pkg::BMD_IDLE: begin
          if (psel && !penable) begin
            state_reg <= bmd_pkg::BMD_DATA;
          end
        end
        bmd_pkg::BMD_DATA: state_reg <= bmd_pkg::BMD_DONE;
        bmd_pkg::BMD_DONE: state_reg <= bmd_pkg::BMD_IDLE;
        default:           state_reg <= bmd_pkg::BMD_IDLE;
      endcase
    end
  end

  // held low while frozen, so no transfer ends without its write
  assign pready  = (state_reg == bmd_pkg::BMD_DONE) && ce;
  assign wr_fire = ce && psel && penable && pready && pwrite && mapped;

  // read value selection
  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_data) begin
      unique case (kind)
        bmd_pkg::BMD_K_NONE:   rd_val = 32'h0000_0000;
        bmd_pkg::BMD_K_PCNT_LOW: rd_val = {24'h00_0000, pcb.pc[7:0]};
        bmd_pkg::BMD_K_STATUS: rd_val = {24'h00_0000, status_reg};
        bmd_pkg::BMD_K_FSP:    rd_val = {24'h00_0000, fsp_reg};
        bmd_pkg::BMD_K_PCNT_LATCH: rd_val = {24'h00_0000, pc_latch_reg};
        bmd_pkg::BMD_K_PORT:   rd_val = {24'h00_0000, port_reg[port_sel]};
        bmd_pkg::BMD_K_GPR:    rd_val = {24'h00_0000, mem.rdata};
        default:               rd_val = 32'h0000_0000;
      endcase
    end else if (mapped) begin
      unique case (idx)
        `BMD_IDX_PMR_ADDR_LO: rd_val = {24'h00_0000, pmr_addr_reg[7:0]};
        `BMD_IDX_PMR_ADDR_HI: rd_val = {27'h000_0000, pmr_addr_reg[12:8]};
        `BMD_IDX_PMR_DATA_LO: rd_val = {24'h00_0000, pmr_data_reg[7:0]};
        `BMD_IDX_PMR_DATA_HI: rd_val = {26'h000_0000, pmr_data_reg[13:8]};
        `BMD_IDX_PC_LO:       rd_val = {24'h00_0000, pcb.pc[7:0]};
        `BMD_IDX_PC_HI:       rd_val = {27'h000_0000, pcb.pc[12:8]};
        default:              rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce && state_reg == bmd_pkg::BMD_DATA) begin
      prdata_reg  <= rd_val;
      pslverr_reg <= !mapped;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ram access, data bus apart from program fetch
  assign mem.addr  = phys;
  assign mem.wdata = pwdata[7:0];
  assign mem.we    = wr_fire && in_data && (kind == bmd_pkg::BMD_K_GPR);

  // core registers, one copy reached from every bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= `BMD_RST_STATUS;
    end else if (wr_fire && in_data && kind == bmd_pkg::BMD_K_STATUS) begin
      status_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fsp_reg <= `BMD_RST_BYTE;
    end else if (wr_fire && in_data && kind == bmd_pkg::BMD_K_FSP) begin
      fsp_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_latch_reg <= `BMD_RST_BYTE;
    end else if (wr_fire && in_data &&
                 kind == bmd_pkg::BMD_K_PCNT_LATCH) begin
      pc_latch_reg <= pwdata[7:0];
    end
  end

  // fourth and fifth port data and direction storage
  for (genvar g = 0; g < 4; g++) begin : g_port
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        port_reg[g] <= `BMD_RST_BYTE;
      end else if (wr_fire && in_data && kind == bmd_pkg::BMD_K_PORT &&
                   port_sel == 2'(g)) begin
        port_reg[g] <= pwdata[7:0];
      end
    end
  end

  // program counter control
  assign pcb.step     = core_step;
  assign pcb.irq      = core_irq_take;
  assign pcb.load     = wr_fire && in_data && kind == bmd_pkg::BMD_K_PCNT_LOW;
  assign pcb.load_val = {pc_latch_reg[4:0], pwdata[7:0]};
  assign pm_fetch_addr = pcb.pc;

  // program memory read path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pmr_addr_reg <= 13'h0000;
    end else if (wr_fire && idx == `BMD_IDX_PMR_ADDR_LO) begin
      pmr_addr_reg[7:0] <= pwdata[7:0];
    end else if (wr_fire && idx == `BMD_IDX_PMR_ADDR_HI) begin
      pmr_addr_reg[12:8] <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pmr_data_reg <= 14'h0000;
    end else if (ce) begin
      pmr_data_reg <= pm_rd_data;
    end
  end

  assign pm_rd_addr = pmr_addr_reg & PMASK;

endmodule : bmd_top
